// ==== fps_pkg.sv ====
// fps_pkg: constants shared by the flash power-state sequencer ends
// assumes a single 50 MHz system clock on both ends
package fps_pkg;
   localparam int CLK_MHZ               = 50;
   localparam int READ_ADMIT_US         = 70;
   localparam int PROGRAM_ADMIT_MS      = 3;
   localparam int DEEP_ENTER_US         = 2;
   localparam int ULTRA_ENTER_US        = 3;
   localparam int ULTRA_WAKE_LOW_NS     = 20;
   localparam int ULTRA_EXIT_US         = 70;
   localparam int RESUME_STANDBY_US     = 8;
   // the ns minimum rounds up to whole cycles; the us and ms times convert exactly, with no clamp
   localparam int READ_ADMIT_CYC        = READ_ADMIT_US * CLK_MHZ;
   localparam int PROGRAM_ADMIT_CYC     = PROGRAM_ADMIT_MS * 1000 * CLK_MHZ;
   localparam int DEEP_ENTER_CYC        = DEEP_ENTER_US * CLK_MHZ;
   localparam int ULTRA_ENTER_CYC       = ULTRA_ENTER_US * CLK_MHZ;
   localparam int ULTRA_WAKE_LOW_CYC    = (ULTRA_WAKE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int ULTRA_EXIT_CYC        = ULTRA_EXIT_US * CLK_MHZ;
   localparam int RESUME_STANDBY_CYC    = RESUME_STANDBY_US * CLK_MHZ;
   localparam int CNT_W                 = 18;
   // power-down requests decoded by the command logic
   localparam logic [1:0] REQ_NONE      = 2'h0;
   localparam logic [1:0] REQ_DEEP      = 2'h1;
   localparam logic [1:0] REQ_ULTRA     = 2'h2;
   localparam logic [1:0] REQ_RESUME    = 2'h3;
   localparam logic [1:0] SPI_MODE_0    = 2'h0;
   localparam logic [1:0] SPI_MODE_3    = 2'h3;
endpackage

// ==== fps_link_if.sv ====
// fps_link_if: pins between the spi host and the flash power sequencer
// the host end resolves the data-out wire from so_oe_n
`timescale 1ns/1ns
`default_nettype none
interface fps_link_if;
   logic chip_select_n;
   logic sclk;
   logic so_out;
   logic so_oe_n;
   modport dev  (input chip_select_n, input sclk, output so_out, output so_oe_n);
   modport host (output chip_select_n, output sclk, input so_out, input so_oe_n);
endinterface
`default_nettype wire

// ==== fps_device.sv ====
// fps_device: power-state and power-up sequencing of a serial flash
// assumes pins arrive asynchronously and a 50 MHz clock; sys_rst models power-on reset
`timescale 1ns/1ns
`default_nettype none
module fps_device #(
   parameter int PROGRAM_ADMIT_CYC = fps_pkg::PROGRAM_ADMIT_CYC,
   parameter int ULTRA_EXIT_CYC    = fps_pkg::ULTRA_EXIT_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // link
   fps_link_if.dev         link,
   // command logic side
   input  wire logic [1:0] pd_req,
   input  wire logic       so_drive_req,
   input  wire logic       so_data,
   // status
   output var  logic       cmd_accept,
   output var  logic       program_admit,
   output var  logic       spi_mode3,
   output var  logic [6:0] power_state
);
   typedef enum logic [6:0] {
      ST_RESET   = 7'h01,
      ST_PUDELAY = 7'h02,
      ST_STANDBY = 7'h04,
      ST_ACTIVE  = 7'h08,
      ST_DEEP    = 7'h10,
      ST_ULTRA   = 7'h20,
      ST_WAKE    = 7'h40
   } fps_state_type;

   typedef struct packed {
      logic [1:0]               cs_sync;
      logic [1:0]               ck_sync;
      logic                     cs_prev;
      fps_state_type            state;
      logic [fps_pkg::CNT_W-1:0] pu_cnt;
      logic [fps_pkg::CNT_W-1:0] pd_cnt;
      logic [1:0]               pd_pend;
      logic                     armed;
      logic                     admit;
      logic                     mode3;
      logic                     so_q;
      logic                     so_oe_n;
   } fps_dev_type;

   fps_dev_type r_ff, nxt_r;
   logic        cs_n, cs_fall, cs_rise;

   assign link.so_out  = r_ff.so_q;
   assign link.so_oe_n = r_ff.so_oe_n;
   assign cmd_accept    = r_ff.armed;
   assign program_admit = r_ff.admit;
   assign spi_mode3     = r_ff.mode3;
   assign power_state   = r_ff.state;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.cs_sync = {r_ff.cs_sync[0], link.chip_select_n};
      nxt_r.ck_sync = {r_ff.ck_sync[0], link.sclk};
      cs_n    = r_ff.cs_sync[1];
      cs_fall = r_ff.cs_prev & ~cs_n;
      cs_rise = ~r_ff.cs_prev & cs_n;
      nxt_r.cs_prev = cs_n;
      if (cs_fall) begin
         nxt_r.mode3 = r_ff.ck_sync[1];
      end
      if (r_ff.pu_cnt != fps_pkg::CNT_W'(PROGRAM_ADMIT_CYC)) begin
         nxt_r.pu_cnt = r_ff.pu_cnt + 1'b1;
      end else begin
         nxt_r.admit = 1'b1;
      end
      // output drives only while a command in the active state asks for it
      nxt_r.so_oe_n = ~(so_drive_req & ~cs_n & (r_ff.state == ST_ACTIVE) & r_ff.armed);
      nxt_r.so_q    = so_data;
      unique case (r_ff.state)
         ST_RESET: begin
            nxt_r.state = ST_PUDELAY;
         end
         ST_PUDELAY: begin
            if (nxt_r.admit) begin
               nxt_r.state = cs_n ? ST_STANDBY : ST_ACTIVE;
            end
         end
         ST_STANDBY: begin
            if (cs_fall) begin
               nxt_r.state = ST_ACTIVE;
               nxt_r.armed = 1'b1;
            end
         end
         ST_ACTIVE: begin
            // power-down request is taken once, at the select rise that ends the frame
            if (cs_rise) begin
               nxt_r.armed = 1'b0;
               if (pd_req == fps_pkg::REQ_DEEP || pd_req == fps_pkg::REQ_ULTRA) begin
                  nxt_r.pd_pend = pd_req;
                  nxt_r.pd_cnt  = '0;
               end else begin
                  nxt_r.state = ST_STANDBY;
               end
            end
            if (r_ff.pd_pend != fps_pkg::REQ_NONE) begin
               nxt_r.pd_cnt = r_ff.pd_cnt + 1'b1;
               if (r_ff.pd_pend == fps_pkg::REQ_DEEP
                   && r_ff.pd_cnt == fps_pkg::CNT_W'(fps_pkg::DEEP_ENTER_CYC - 2)) begin
                  nxt_r.state   = ST_DEEP;
                  nxt_r.pd_pend = fps_pkg::REQ_NONE;
               end
               if (r_ff.pd_pend == fps_pkg::REQ_ULTRA
                   && r_ff.pd_cnt == fps_pkg::CNT_W'(fps_pkg::ULTRA_ENTER_CYC - 2)) begin
                  nxt_r.state   = ST_ULTRA;
                  nxt_r.pd_pend = fps_pkg::REQ_NONE;
               end
            end
         end
         ST_DEEP: begin
            // only a resume command releases deep power-down
            if (cs_fall) begin
               nxt_r.armed = 1'b1;
            end
            if (cs_rise && r_ff.armed) begin
               nxt_r.armed = 1'b0;
               if (pd_req == fps_pkg::REQ_RESUME) begin
                  nxt_r.pd_pend = fps_pkg::REQ_RESUME;
                  nxt_r.pd_cnt  = '0;
               end
            end
            if (r_ff.pd_pend == fps_pkg::REQ_RESUME) begin
               nxt_r.pd_cnt = r_ff.pd_cnt + 1'b1;
               if (r_ff.pd_cnt == fps_pkg::CNT_W'(fps_pkg::RESUME_STANDBY_CYC - 2)) begin
                  nxt_r.state   = ST_STANDBY;
                  nxt_r.pd_pend = fps_pkg::REQ_NONE;
               end
            end
         end
         ST_ULTRA: begin
            if (cs_fall) begin
               nxt_r.state  = ST_WAKE;
               nxt_r.pd_cnt = '0;
            end
         end
         ST_WAKE: begin
            nxt_r.pd_cnt = r_ff.pd_cnt + 1'b1;
            if (r_ff.pd_cnt == fps_pkg::CNT_W'(ULTRA_EXIT_CYC - 1)) begin
               nxt_r.state = ST_STANDBY;
            end
         end
         default: begin
            nxt_r.state = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_ff         <= '0;
         r_ff.cs_sync <= 2'h3;
         r_ff.cs_prev <= 1'b1;
         r_ff.state   <= ST_RESET;
         r_ff.so_oe_n <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end
endmodule // fps_device
`default_nettype wire

// ==== fps_host.sv ====
// fps_host: spi host end that sequences power-up and power-down commands
// assumes the device end on the same 50 MHz clock; data-out passes a synchroniser
`timescale 1ns/1ns
`default_nettype none
module fps_host #(
   parameter int PROGRAM_ADMIT_CYC = fps_pkg::PROGRAM_ADMIT_CYC,
   parameter int ULTRA_EXIT_CYC    = fps_pkg::ULTRA_EXIT_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // link
   fps_link_if.host        link,
   // user side
   input  wire logic       frame_req,
   input  wire logic       frame_is_program,
   input  wire logic       wake_req,
   input  wire logic       wp_locked,
   output var  logic       frame_busy,
   output var  logic       host_ready,
   output var  logic       so_seen
);
   typedef enum logic [3:0] {
      HS_WAIT  = 4'h1,
      HS_IDLE  = 4'h2,
      HS_FRAME = 4'h4,
      HS_WAKE  = 4'h8
   } fps_hstate_type;

   typedef struct packed {
      fps_hstate_type            state;
      logic [fps_pkg::CNT_W-1:0] pu_cnt;
      logic [fps_pkg::CNT_W-1:0] cnt;
      logic                      cs_n;
      logic                      busy;
      logic [1:0]                so_sync;
      logic                      ultra_wait;
   } fps_host_type;

   // the power-up counter must run up to both admission delays, whichever is longer, and then holds
   localparam int PU_LIMIT = (PROGRAM_ADMIT_CYC > fps_pkg::READ_ADMIT_CYC) ? PROGRAM_ADMIT_CYC
                                                                           : fps_pkg::READ_ADMIT_CYC;

   fps_host_type r_ff, nxt_r;
   logic         read_ok, prog_ok;

   assign link.chip_select_n = r_ff.cs_n;
   assign link.sclk          = 1'b0;
   assign frame_busy = r_ff.busy;
   assign host_ready = (r_ff.state == HS_IDLE);
   assign so_seen    = r_ff.so_sync[1];

   always_comb begin
      nxt_r = r_ff;
      nxt_r.so_sync = {r_ff.so_sync[0], link.so_out & ~link.so_oe_n};
      if (r_ff.pu_cnt != fps_pkg::CNT_W'(PU_LIMIT)) begin
         nxt_r.pu_cnt = r_ff.pu_cnt + 1'b1;
      end
      read_ok = (r_ff.pu_cnt >= fps_pkg::CNT_W'(fps_pkg::READ_ADMIT_CYC));
      prog_ok = (r_ff.pu_cnt >= fps_pkg::CNT_W'(PROGRAM_ADMIT_CYC));
      // wp setup/hold are met trivially: wp is not toggled by this host
      unique case (r_ff.state)
         HS_WAIT: begin
            if (read_ok) begin
               nxt_r.state = HS_IDLE;
            end
         end
         HS_IDLE: begin
            if (wake_req) begin
               nxt_r.cs_n  = 1'b0;
               nxt_r.cnt   = '0;
               nxt_r.state = HS_WAKE;
            end else if (frame_req && (!frame_is_program || prog_ok)) begin
               nxt_r.cs_n  = 1'b0;
               nxt_r.busy  = 1'b1;
               nxt_r.cnt   = '0;
               nxt_r.state = HS_FRAME;
            end
         end
         HS_FRAME: begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
            if (r_ff.cnt == fps_pkg::CNT_W'(7)) begin
               nxt_r.cs_n  = 1'b1;
               nxt_r.busy  = 1'b0;
               nxt_r.state = HS_IDLE;
            end
         end
         HS_WAKE: begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
            if (r_ff.cnt == fps_pkg::CNT_W'(fps_pkg::ULTRA_WAKE_LOW_CYC)) begin
               nxt_r.cs_n = 1'b1;
            end
            if (r_ff.cnt == fps_pkg::CNT_W'(ULTRA_EXIT_CYC + 2)) begin
               nxt_r.state = HS_IDLE;
            end
         end
         default: begin
            nxt_r.state = HS_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_ff       <= '0;
         r_ff.state <= HS_WAIT;
         r_ff.cs_n  <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end
endmodule // fps_host
`default_nettype wire

// ==== fps_properties.sv ====
// fps_properties: timing checks on the link joining host and device ends
// assumes the testbench wires the link and the device status ports in by name
`timescale 1ns/1ns
`default_nettype none
module fps_properties #(
   parameter int PROGRAM_ADMIT_CYC = fps_pkg::PROGRAM_ADMIT_CYC,
   parameter int ULTRA_EXIT_CYC    = fps_pkg::ULTRA_EXIT_CYC
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // link and device status
   input wire logic       chip_select_n,
   input wire logic       sclk,
   input wire logic       so_oe_n,
   input wire logic [1:0] pd_req,
   input wire logic       cmd_accept,
   input wire logic       program_admit,
   input wire logic       spi_mode3,
   input wire logic [6:0] power_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   int up_cnt_ff;
   int wake_cnt_ff;
   // cycles since reset release, and cycles spent recovering from ultra sleep
   always_ff @(posedge clk) begin
      up_cnt_ff   <= sys_rst ? 0 : up_cnt_ff + 1;
      wake_cnt_ff <= (power_state == 7'h40) ? wake_cnt_ff + 1 : 0;
   end
   a_reset_hi_z: assert property (disable iff (1'b0) sys_rst |=> so_oe_n)
      else $error("data out driven after reset");
   a_reset_all_off: assert property (disable iff (1'b0) sys_rst |=> power_state == 7'h01 && !cmd_accept)
      else $error("device active during reset");
   a_accept_on_fall: assert property ($fell(chip_select_n) && power_state == 7'h04 |-> ##[2:6] cmd_accept)
      else $error("select fall not accepted");
   a_accept_needs_sel: assert property ($rose(cmd_accept) |-> !chip_select_n)
      else $error("accept without select low");
   a_mode_sampled: assert property ($rose(cmd_accept) |-> spi_mode3 == $past(sclk, 4))
      else $error("spi mode not from idle clock");
   a_admit_delay: assert property ($rose(program_admit) |-> up_cnt_ff >= PROGRAM_ADMIT_CYC)
      else $error("program admitted too early");
   a_delay_exit: assert property ($fell(power_state == 7'h02) |-> power_state inside {7'h04, 7'h08})
      else $error("bad state after power-up delay");
   a_deep_entry: assert property ($rose(chip_select_n) && power_state == 7'h08 && pd_req == fps_pkg::REQ_DEEP
      |-> ##[1:110] power_state == 7'h10)
      else $error("deep sleep not reached in time");
   a_ultra_entry: assert property ($rose(chip_select_n) && power_state == 7'h08 && pd_req == fps_pkg::REQ_ULTRA
      |-> ##[1:160] power_state == 7'h20)
      else $error("ultra sleep not reached in time");
   a_resume_exit: assert property ($rose(chip_select_n) && power_state == 7'h10 && pd_req == fps_pkg::REQ_RESUME
      |-> ##[1:410] power_state == 7'h04)
      else $error("resume to standby too slow");
   a_wake_recover: assert property ($fell(power_state == 7'h40) |-> wake_cnt_ff >= ULTRA_EXIT_CYC - 1)
      else $error("ultra wake recovery cut short");
endmodule // fps_properties
`default_nettype wire

// ==== flash_power_state_sequencer_tb_top.sv ====
// flash_power_state_sequencer_tb_top: host and device ends joined, plus a lone device driven by hand
// assumes shortened program-admit and wake counts on both ends; the host read-admit wait is not shortened
`timescale 1ns/1ns
`default_nettype none
module flash_power_state_sequencer_tb_top;
   localparam int PA = 200;
   localparam int UE = 50;
   logic       clk = 1'b0, sys_rst = 1'b1, frame_req = 1'b0, wake_req = 1'b0;
   logic [1:0] pd_req = fps_pkg::REQ_NONE;
   logic       frame_busy, host_ready, so_seen, cmd_accept, program_admit, spi_mode3;
   logic [6:0] power_state, power_state_b;
   logic       so_drive_req_b = 1'b0, so_data_b = 1'b0, cmd_accept_b, program_admit_b, spi_mode3_b;
   int         err_count = 0, comparisons = 0;
   fps_link_if link ();
   fps_link_if link_b ();
   fps_host #(.PROGRAM_ADMIT_CYC(PA), .ULTRA_EXIT_CYC(UE)) fps_host_inst (.clk(clk), .sys_rst(sys_rst),
      .link(link.host), .frame_req(frame_req), .frame_is_program(1'b0), .wake_req(wake_req), .wp_locked(1'b0),
      .frame_busy(frame_busy), .host_ready(host_ready), .so_seen(so_seen));
   fps_device #(.PROGRAM_ADMIT_CYC(PA), .ULTRA_EXIT_CYC(UE)) fps_device_inst (.clk(clk), .sys_rst(sys_rst),
      .link(link.dev), .pd_req(pd_req), .so_drive_req(1'b0), .so_data(1'b0), .cmd_accept(cmd_accept),
      .program_admit(program_admit), .spi_mode3(spi_mode3), .power_state(power_state));
   // second device with its pins driven straight from the bench
   fps_device #(.PROGRAM_ADMIT_CYC(PA), .ULTRA_EXIT_CYC(UE)) fps_device_inst_b (.clk(clk), .sys_rst(sys_rst),
      .link(link_b.dev), .pd_req(fps_pkg::REQ_NONE), .so_drive_req(so_drive_req_b), .so_data(so_data_b),
      .cmd_accept(cmd_accept_b), .program_admit(program_admit_b), .spi_mode3(spi_mode3_b),
      .power_state(power_state_b));
   fps_properties #(.PROGRAM_ADMIT_CYC(PA), .ULTRA_EXIT_CYC(UE)) fps_properties_inst (.clk(clk),
      .sys_rst(sys_rst), .chip_select_n(link.chip_select_n), .sclk(link.sclk), .so_oe_n(link.so_oe_n),
      .pd_req(pd_req), .cmd_accept(cmd_accept), .program_admit(program_admit), .spi_mode3(spi_mode3),
      .power_state(power_state));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_ps(input logic [6:0] exp);
      comparisons++;
      if (power_state !== exp) begin
         err_count++;
         $display("mismatch at %0t: state %h expected %h", $time, power_state, exp);
         tally_and_finish();
      end
   endtask
   task automatic wait_ps(input logic [6:0] exp, input int lim);
      for (int i = 0; i < lim && power_state !== exp; i++) step(1);
      chk_ps(exp);
   endtask
   task automatic frame(input logic [1:0] req);
      pd_req = req;
      frame_req = 1'b1;
      for (int i = 0; i < 20 && frame_busy !== 1'b1; i++) step(1);
      chk_bit(frame_busy, 1'b1);
      frame_req = 1'b0;
      for (int i = 0; i < 40 && frame_busy !== 1'b0; i++) step(1);
      chk_bit(frame_busy, 1'b0);
   endtask
   task automatic sel_b(input logic cs, input logic ck);
      link_b.sclk = ck;
      link_b.chip_select_n = cs;
      step(8);
   endtask
   initial begin
      link_b.chip_select_n = 1'b1;
      link_b.sclk = 1'b0;
      step(12);
      sys_rst = 1'b0;
      step(3);
      chk_bit(link.so_oe_n, 1'b1);
      sel_b(1'b0, 1'b0);
      chk_bit(cmd_accept_b, 1'b0);
      chk_bit(program_admit, 1'b0);
      sel_b(1'b1, 1'b0);
      wait_ps(7'h04, PA + 20);
      chk_bit(program_admit, 1'b1);
      chk_bit(host_ready, 1'b0);
      sel_b(1'b1, 1'b1);
      sel_b(1'b0, 1'b1);
      chk_bit(cmd_accept_b, 1'b1);
      chk_bit(spi_mode3_b, 1'b1);
      so_drive_req_b = 1'b1;
      so_data_b = 1'b1;
      step(4);
      chk_bit(link_b.so_oe_n, 1'b0);
      so_drive_req_b = 1'b0;
      sel_b(1'b1, 1'b0);
      sel_b(1'b0, 1'b0);
      chk_bit(spi_mode3_b, 1'b0);
      sel_b(1'b1, 1'b0);
      for (int i = 0; i < fps_pkg::READ_ADMIT_CYC + 50 && host_ready !== 1'b1; i++) step(1);
      chk_bit(host_ready, 1'b1);
      frame(fps_pkg::REQ_DEEP);
      wait_ps(7'h10, 120);
      frame(fps_pkg::REQ_RESUME);
      wait_ps(7'h04, 420);
      frame(fps_pkg::REQ_ULTRA);
      wait_ps(7'h20, 170);
      wake_req = 1'b1;
      wait_ps(7'h40, 60);
      wake_req = 1'b0;
      wait_ps(7'h04, UE + 100);
      tally_and_finish();
   end
endmodule // flash_power_state_sequencer_tb_top
`default_nettype wire
